/* rtl/sensor_param.sv */
// Parameter registers, option flags, supervision alarms and status readout of the sensor.
// Assumes the register master keeps strobes one cycle long and the alarm taker uses ready.
`timescale 1ns/1ns
module sensor_param #(
    parameter int MS_CYCLES = sensor_param_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [9:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Sensor conditions
    input  wire logic        lin_table_stored,
    input  wire logic        magnets_more,
    input  wire logic        magnets_fewer,
    input  wire logic        supply_high,
    input  wire logic        supply_low,
    // Status word feed
    input  wire logic        status_wr,
    input  wire logic [4:0]  status_idx,
    input  wire logic [31:0] status_data,
    // Alarm message channel
    output logic             alarm_valid,
    input  wire logic        alarm_ready,
    output logic      [15:0] alarm_code,
    // Settings to the measuring path
    output logic      [1:0]  filter_type,
    output logic      [4:0]  filter_window,
    output logic      [4:0]  velocity_window,
    output logic             extrap_on,
    output logic             lin_on,
    output logic      [31:0] preset_value,
    output logic             preset_load,
    output logic      [31:0] profile_override_param
);
    typedef struct packed {
        logic [1:0]  filter_type;
        logic [4:0]  filter_window;
        logic [4:0]  velocity_window;
        logic        extrap;
        logic        lin;
        logic [1:0]  magnet_mode;
        logic [1:0]  supply_mode;
        logic [31:0] flags1;
        logic [31:0] flags2;
        logic [31:0] flags3;
        logic [31:0] override;
        logic [31:0] preset_value;
        logic        preset_load;
        logic        preset_rejected;
        logic [15:0] cycle_time_us;
        logic [3:0]  pending;
        logic [3:0]  cond_prev;
        logic        alarm_busy;
        logic [15:0] alarm_code;
        logic [15:0] last_alarm;
        logic [31:0] rdata;
        logic        rd_mem;
        logic [31:0] ms_div;
        logic [31:0] age_ms;
    } param_state_type;

    param_state_type s;
    param_state_type next_s;

    logic [3:0]  cond;
    logic [3:0]  events;
    logic        param_error;
    logic        in_status;
    logic [9:0]  status_ofs;
    logic [4:0]  status_sel;
    logic [31:0] mem_rdata;

    assign in_status  = reg_addr >= sensor_param_pkg::STATUS_BASE
                        && reg_addr < sensor_param_pkg::STATUS_END && reg_addr[1:0] == 2'h0;
    assign status_ofs = reg_addr - sensor_param_pkg::STATUS_BASE;
    assign status_sel = status_ofs[6:2];

    status_mem u_status_mem (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (status_wr),
        .wr_idx  (status_idx),
        .wr_data (status_data),
        .rd_idx  (status_sel),
        .rd_data (mem_rdata)
    );

    function automatic logic [15:0] code_of(input int idx);
        case (idx)
            3:       code_of = sensor_param_pkg::CODE_V_HIGH;
            2:       code_of = sensor_param_pkg::CODE_V_LOW;
            1:       code_of = sensor_param_pkg::CODE_MAGNET;
            default: code_of = sensor_param_pkg::CODE_PARAM;
        endcase
    endfunction

    // Supervised conditions, qualified by their modes; edges become alarm events.
    always_comb begin
        cond[3] = supply_high && (s.supply_mode == sensor_param_pkg::SUP_BOTH
                  || s.supply_mode == sensor_param_pkg::SUP_HIGH);
        cond[2] = supply_low && (s.supply_mode == sensor_param_pkg::SUP_BOTH
                  || s.supply_mode == sensor_param_pkg::SUP_LOW);
        cond[1] = (magnets_more && (s.magnet_mode == sensor_param_pkg::SUP_BOTH
                  || s.magnet_mode == sensor_param_pkg::SUP_HIGH))
                  || (magnets_fewer && (s.magnet_mode == sensor_param_pkg::SUP_BOTH
                  || s.magnet_mode == sensor_param_pkg::SUP_LOW));
        cond[0] = 1'b0;
    end

    always_comb begin
        next_s = s;
        param_error = 1'b0;
        next_s.preset_load = 1'b0;
        next_s.rd_mem = 1'b0;
        next_s.rdata = 32'h0;
        next_s.cond_prev = cond;

        if (reg_write) begin
            case (reg_addr)
                sensor_param_pkg::OFS_FILTER_TYPE: begin
                    if (reg_wdata <= 32'h2) begin
                        next_s.filter_type = reg_wdata[1:0];
                    end else begin
                        param_error = 1'b1;
                    end
                end
                sensor_param_pkg::OFS_FILTER_WIN: begin
                    if (reg_wdata >= sensor_param_pkg::WIN_MIN
                        && reg_wdata <= sensor_param_pkg::WIN_MAX) begin
                        next_s.filter_window = reg_wdata[4:0];
                    end else begin
                        param_error = 1'b1;
                    end
                end
                sensor_param_pkg::OFS_VELOCITY_WIN: begin
                    if (reg_wdata >= sensor_param_pkg::WIN_MIN
                        && reg_wdata <= sensor_param_pkg::WIN_MAX) begin
                        next_s.velocity_window = reg_wdata[4:0];
                    end else begin
                        param_error = 1'b1;
                    end
                end
                sensor_param_pkg::OFS_EXTRAP: begin
                    // Oversampling below the least cycle time would be meaningless.
                    if (reg_wdata[0] && s.cycle_time_us < sensor_param_pkg::MIN_CYCLE_US) begin
                        param_error = 1'b1;
                    end else begin
                        next_s.extrap = reg_wdata[0];
                    end
                end
                sensor_param_pkg::OFS_LINEAR: begin
                    if (reg_wdata[0] && !lin_table_stored) begin
                        param_error = 1'b1;
                    end else begin
                        next_s.lin = reg_wdata[0];
                    end
                end
                sensor_param_pkg::OFS_MAGNET_MODE: begin
                    next_s.magnet_mode = reg_wdata[1:0];
                end
                sensor_param_pkg::OFS_SUPPLY_MODE: begin
                    next_s.supply_mode = reg_wdata[1:0];
                end
                sensor_param_pkg::OFS_FLAGS1: begin
                    // Only bits 2 and 3 steer anything; the rest are stored only.
                    next_s.flags1 = reg_wdata;
                    if (reg_wdata[sensor_param_pkg::OVERRIDE_BIT]) begin
                        next_s.override = s.flags2;
                    end
                end
                sensor_param_pkg::OFS_FLAGS2: begin
                    next_s.flags2 = reg_wdata;
                    if (s.flags1[sensor_param_pkg::OVERRIDE_BIT]) begin
                        next_s.override = reg_wdata;
                    end
                end
                sensor_param_pkg::OFS_FLAGS3: begin
                    next_s.flags3 = reg_wdata;
                end
                sensor_param_pkg::OFS_STATUS: begin
                    if (reg_wdata[16]) begin
                        next_s.preset_rejected = 1'b0;
                    end
                end
                sensor_param_pkg::OFS_PRESET: begin
                    if (reg_wdata[31] && !s.flags1[sensor_param_pkg::NEG_PRESET_BIT]) begin
                        next_s.preset_rejected = 1'b1;
                    end else begin
                        next_s.preset_value = reg_wdata;
                        next_s.preset_load = 1'b1;
                    end
                end
                sensor_param_pkg::OFS_CYCLE_TIME: begin
                    next_s.cycle_time_us = reg_wdata[15:0];
                end
                default: begin
                end
            endcase
        end

        if (reg_read) begin
            if (in_status) begin
                if (status_sel == 5'h00) begin
                    next_s.rdata = sensor_param_pkg::STATUS_COUNT;
                end else if (status_sel == 5'h01) begin
                    next_s.rdata = s.age_ms;
                end else begin
                    next_s.rd_mem = 1'b1;
                end
            end else begin
                case (reg_addr)
                    sensor_param_pkg::OFS_FILTER_TYPE:  next_s.rdata = {30'h0, s.filter_type};
                    sensor_param_pkg::OFS_FILTER_WIN:   next_s.rdata = {27'h0, s.filter_window};
                    sensor_param_pkg::OFS_VELOCITY_WIN: next_s.rdata = {27'h0, s.velocity_window};
                    sensor_param_pkg::OFS_EXTRAP:       next_s.rdata = {31'h0, s.extrap};
                    sensor_param_pkg::OFS_LINEAR:       next_s.rdata = {31'h0, s.lin};
                    sensor_param_pkg::OFS_MAGNET_MODE:  next_s.rdata = {30'h0, s.magnet_mode};
                    sensor_param_pkg::OFS_SUPPLY_MODE:  next_s.rdata = {30'h0, s.supply_mode};
                    sensor_param_pkg::OFS_FLAGS1:       next_s.rdata = s.flags1;
                    sensor_param_pkg::OFS_FLAGS2:       next_s.rdata = s.flags2;
                    sensor_param_pkg::OFS_FLAGS3:       next_s.rdata = s.flags3;
                    sensor_param_pkg::OFS_OVERRIDE:     next_s.rdata = s.override;
                    sensor_param_pkg::OFS_STATUS:
                        next_s.rdata = {13'h0, s.alarm_busy, s.pending[0],
                                        s.preset_rejected, s.last_alarm};
                    sensor_param_pkg::OFS_PRESET:       next_s.rdata = s.preset_value;
                    sensor_param_pkg::OFS_CYCLE_TIME:   next_s.rdata = {16'h0, s.cycle_time_us};
                    default:                            next_s.rdata = 32'h0;
                endcase
            end
        end

        // Fresh status words restart the age; otherwise it counts milliseconds.
        if (status_wr) begin
            next_s.ms_div = 32'h0;
            next_s.age_ms = 32'h0;
        end else if (s.ms_div == 32'(MS_CYCLES - 1)) begin
            next_s.ms_div = 32'h0;
            next_s.age_ms = s.age_ms + 32'h1;
        end else begin
            next_s.ms_div = s.ms_div + 32'h1;
        end

        // Every diagnostic but a rejected preset goes out as a message; a new event beats the clear.
        events = (cond & ~s.cond_prev) | {3'h0, param_error};
        next_s.pending = s.pending | events;
        if (s.alarm_busy) begin
            if (alarm_ready) begin
                next_s.alarm_busy = 1'b0;
            end
        end else if (|s.pending) begin
            for (int i = 0; i < 4; i++) begin
                if (s.pending[i]) begin
                    next_s.alarm_code = code_of(i);
                    next_s.pending = (s.pending & ~(4'h1 << i)) | events;
                end
            end
            next_s.alarm_busy = 1'b1;
            next_s.last_alarm = next_s.alarm_code;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.filter_type <= sensor_param_pkg::FILTER_NONE;
            s.filter_window <= sensor_param_pkg::FILTER_WIN_RESET;
            s.velocity_window <= sensor_param_pkg::VEL_WIN_RESET;
            s.magnet_mode <= sensor_param_pkg::SUP_OFF;
            s.supply_mode <= sensor_param_pkg::SUP_OFF;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rd_mem ? mem_rdata : s.rdata;
    assign alarm_valid = s.alarm_busy;
    assign alarm_code = s.alarm_code;
    assign filter_type = s.filter_type;
    assign filter_window = s.filter_window;
    assign velocity_window = s.velocity_window;
    assign extrap_on = s.extrap;
    assign lin_on = s.lin;
    assign preset_value = s.preset_value;
    assign preset_load = s.preset_load;
    assign profile_override_param = s.override;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence wr_at(logic [9:0] a);
        reg_write && reg_addr == a;
    endsequence

    filter_select_a: assert property (wr_at(sensor_param_pkg::OFS_FILTER_TYPE)
        && reg_wdata <= 32'h2 |=> filter_type == $past(reg_wdata[1:0]))
        else $error("filter type not taken");
    filter_window_a: assert property (wr_at(sensor_param_pkg::OFS_FILTER_WIN)
        && reg_wdata >= 32'h2 && reg_wdata <= 32'h10
        |=> filter_window == $past(reg_wdata[4:0]))
        else $error("filter window not taken");
    velocity_window_a: assert property (wr_at(sensor_param_pkg::OFS_VELOCITY_WIN)
        && reg_wdata >= 32'h2 && reg_wdata <= 32'h10
        |=> velocity_window == $past(reg_wdata[4:0]))
        else $error("velocity window not taken");
    window_keep_a: assert property (wr_at(sensor_param_pkg::OFS_FILTER_WIN)
        && (reg_wdata < 32'h2 || reg_wdata > 32'h10)
        |=> $stable(filter_window) && s.pending[0])
        else $error("bad window changed setting or raised no error");
    extrap_guard_a: assert property (wr_at(sensor_param_pkg::OFS_EXTRAP)
        && reg_wdata[0]
        && s.cycle_time_us < 16'h00fa |=> $stable(extrap_on))
        else $error("extrapolation enabled with short cycle time");
    lin_refuse_a: assert property (wr_at(sensor_param_pkg::OFS_LINEAR)
        && reg_wdata[0]
        && !lin_table_stored |=> $stable(lin_on) && s.pending[0])
        else $error("linearization taken without table");
    magnet_off_a: assert property (s.magnet_mode == 2'h0 && !s.pending[1]
        |=> !s.pending[1])
        else $error("magnet alarm raised while off");
    supply_off_a: assert property (s.supply_mode == 2'h0 && s.pending[3:2] == 2'h0
        |=> s.pending[3:2] == 2'h0)
        else $error("supply alarm raised while off");
    alarm_hold_a: assert property (alarm_valid && !alarm_ready
        |=> alarm_valid && $stable(alarm_code))
        else $error("alarm message dropped before taken");
    neg_preset_a: assert property (wr_at(sensor_param_pkg::OFS_PRESET)
        && reg_wdata[31]
        && !s.flags1[2] |=> !preset_load && s.preset_rejected)
        else $error("negative preset accepted");
    override_load_a: assert property (wr_at(sensor_param_pkg::OFS_FLAGS1)
        && reg_wdata[3]
        |=> profile_override_param == $past(s.flags2))
        else $error("override not loaded from flags2");
    entry_count_a: assert property (reg_read && reg_addr == 10'h100
        |=> reg_rdata == 32'h13 ##1 1'b1)
        else $error("status entry count wrong");
endmodule // sensor_param

/* rtl/sensor_param_pkg.sv */
// Constants shared by the sensor parameter and diagnostic block and its status memory.
// Assumes one 250 MHz system clock and a plain register port with one-cycle reads.
package sensor_param_pkg;
    // Register offsets (byte addresses).
    localparam logic [9:0] OFS_FILTER_TYPE  = 10'h000;
    localparam logic [9:0] OFS_FILTER_WIN   = 10'h004;
    localparam logic [9:0] OFS_VELOCITY_WIN = 10'h008;
    localparam logic [9:0] OFS_EXTRAP       = 10'h00c;
    localparam logic [9:0] OFS_LINEAR       = 10'h010;
    localparam logic [9:0] OFS_MAGNET_MODE  = 10'h014;
    localparam logic [9:0] OFS_SUPPLY_MODE  = 10'h018;
    localparam logic [9:0] OFS_FLAGS1       = 10'h01c;
    localparam logic [9:0] OFS_FLAGS2       = 10'h020;
    localparam logic [9:0] OFS_FLAGS3       = 10'h024;
    localparam logic [9:0] OFS_OVERRIDE     = 10'h028;
    localparam logic [9:0] OFS_STATUS       = 10'h02c;
    localparam logic [9:0] OFS_PRESET       = 10'h030;
    localparam logic [9:0] OFS_CYCLE_TIME   = 10'h034;
    localparam logic [9:0] STATUS_BASE      = 10'h100;
    localparam logic [9:0] STATUS_END       = 10'h14c;

    localparam logic [4:0]  STATUS_WORDS    = 5'h13;
    localparam logic [31:0] STATUS_COUNT    = 32'h0000_0013;

    // Filter selections.
    localparam logic [1:0] FILTER_NONE = 2'h0;
    localparam logic [1:0] FILTER_FIR  = 2'h1;
    localparam logic [1:0] FILTER_IIR  = 2'h2;

    // Window limits and reset values.
    localparam logic [31:0] WIN_MIN          = 32'h0000_0002;
    localparam logic [31:0] WIN_MAX          = 32'h0000_0010;
    localparam logic [4:0]  FILTER_WIN_RESET = 5'h02;
    localparam logic [4:0]  VEL_WIN_RESET    = 5'h08;

    // Supervision modes; both alarm kinds share the same encoding.
    localparam logic [1:0] SUP_OFF  = 2'h0;
    localparam logic [1:0] SUP_BOTH = 2'h1;
    localparam logic [1:0] SUP_HIGH = 2'h2;
    localparam logic [1:0] SUP_LOW  = 2'h3;

    // Alarm codes.
    localparam logic [15:0] CODE_PARAM  = 16'h0010;
    localparam logic [15:0] CODE_MAGNET = 16'h9100;
    localparam logic [15:0] CODE_V_LOW  = 16'h9110;
    localparam logic [15:0] CODE_V_HIGH = 16'h9111;

    // Option flag bit positions.
    localparam int NEG_PRESET_BIT = 2;
    localparam int OVERRIDE_BIT   = 3;

    // Timing.
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          MS_NS          = 1000000;
    localparam int          MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] MIN_CYCLE_US   = 16'h00fa;
endpackage

/* rtl/status_mem.sv */
// Nineteen-word status memory with one write port and a registered read port.
// Assumes the writer stays below the word count; other indices are ignored.
`timescale 1ns/1ns
module status_mem (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Write side
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_idx,
    input  wire logic [31:0] wr_data,
    // Read side
    input  wire logic [4:0]  rd_idx,
    output logic      [31:0] rd_data
);
    typedef struct packed {
        logic [18:0][31:0] words;
        logic [31:0]       rd_data;
    } mem_state_type;

    mem_state_type s;
    mem_state_type next_s;

    always_comb begin
        next_s = s;
        if (wr_en && wr_idx < sensor_param_pkg::STATUS_WORDS) begin
            next_s.words[wr_idx] = wr_data;
        end
        next_s.rd_data = (rd_idx < sensor_param_pkg::STATUS_WORDS) ? s.words[rd_idx] : 32'h0;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data = s.rd_data;
endmodule // status_mem

/* verif/alarm_taker.sv */
// Fieldbus controller model that takes alarm messages from the sensor block.
// Assumes it shares the block's clock; slow stretches the wait before ready.
`timescale 1ns/1ns
module alarm_taker (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Alarm channel
    input  wire logic        alarm_valid,
    input  wire logic [15:0] alarm_code,
    output logic             alarm_ready,
    // Test control
    input  wire logic        slow
);
    logic [15:0] got[$];
    int          wait_cnt;
    // Ready is raised only for a waiting message, so a late answer is really late.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            alarm_ready <= 1'h0;
            wait_cnt    <= 0;
        end else if (alarm_valid && alarm_ready) begin
            got.push_back(alarm_code);
            alarm_ready <= 1'h0;
            wait_cnt    <= 0;
        end else if (alarm_valid) begin
            wait_cnt    <= wait_cnt + 1;
            alarm_ready <= !slow || wait_cnt >= 2;
        end
    end
endmodule // alarm_taker

/* verif/tb_top.sv */
// Self-checking bench for the sensor parameter block and its alarm taker.
// Assumes the design package is compiled first; the millisecond count is cut to 10.
`timescale 1ns/1ns
module tb_top;
    logic        sys_clk, rst, reg_write, reg_read, lin_table_stored, magnets_more;
    logic        magnets_fewer, supply_high, supply_low, status_wr, alarm_valid;
    logic        alarm_ready, slow, extrap_on, lin_on, preset_load;
    logic [9:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, status_data, preset_value, profile_override_param;
    logic [4:0]  status_idx, filter_window, velocity_window;
    logic [15:0] alarm_code;
    logic [1:0]  filter_type;
    int          err_count, checks, loads;
    typedef struct packed { logic [9:0] a; logic [31:0] d; logic [31:0] e; } row_type;
    localparam row_type ROWS [20] = '{
        '{10'h000, 32'h1, 32'h1}, '{10'h000, 32'h2, 32'h2}, '{10'h000, 32'h3, 32'h2},
        '{10'h000, 32'h0, 32'h0}, '{10'h004, 32'h10, 32'h10}, '{10'h004, 32'h1, 32'h10},
        '{10'h004, 32'h11, 32'h10}, '{10'h004, 32'h2, 32'h2}, '{10'h008, 32'h2, 32'h2},
        '{10'h008, 32'h10, 32'h10}, '{10'h008, 32'h0, 32'h10}, '{10'h008, 32'h11, 32'h10},
        '{10'h014, 32'h1, 32'h1}, '{10'h014, 32'h2, 32'h2}, '{10'h014, 32'h3, 32'h3},
        '{10'h014, 32'h0, 32'h0}, '{10'h018, 32'h1, 32'h1}, '{10'h018, 32'h2, 32'h2},
        '{10'h018, 32'h3, 32'h3}, '{10'h018, 32'h0, 32'h0}};

    sensor_param #(.MS_CYCLES(10)) sensor_param_i (.sys_clk, .rst, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .lin_table_stored, .magnets_more, .magnets_fewer,
        .supply_high, .supply_low, .status_wr, .status_idx, .status_data, .alarm_valid,
        .alarm_ready, .alarm_code, .filter_type, .filter_window, .velocity_window,
        .extrap_on, .lin_on, .preset_value, .preset_load, .profile_override_param);
    alarm_taker alarm_taker_i (.sys_clk, .rst, .alarm_valid, .alarm_code, .alarm_ready,
        .slow);

    task automatic chk(input logic ok, input string m);
        checks++;
        if (!ok) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge sys_clk);
        reg_write <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge sys_clk);
        reg_read <= 1'h0;
        #1;
        chk(reg_rdata === e, "read data");
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic alarm(input logic [15:0] c);
        for (int n = 0; n < 40 && alarm_taker_i.got.size() == 0; n++) @(posedge sys_clk);
        #1;
        chk(alarm_taker_i.got.size() > 0 && alarm_taker_i.got[0] === c, "alarm code");
        if (alarm_taker_i.got.size() > 0) void'(alarm_taker_i.got.pop_front());
    endtask
    task automatic quiet();
        repeat (10) @(posedge sys_clk);
        #1;
        chk(alarm_taker_i.got.size() == 0, "unexpected alarm");
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge sys_clk) if (preset_load === 1'h1) loads++;
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        final_report();
    end
    initial begin
        rst = 1'h1;
        {reg_write, reg_read, lin_table_stored, magnets_more, magnets_fewer} = 5'h0;
        {supply_high, supply_low, status_wr, slow} = 4'h0;
        {reg_addr, reg_wdata, status_idx, status_data} = '0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'h0;
        #1;
        chk(filter_type === 2'h0 && extrap_on === 1'h0 && lin_on === 1'h0, "reset");
        chk(filter_window === 5'h02 && velocity_window === 5'h08, "reset win");
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            rd(ROWS[i].a, ROWS[i].e);
        end
        repeat (20) @(posedge sys_clk);
        #1;
        alarm_taker_i.got.delete();
        {supply_high, magnets_more} <= 2'h3;
        quiet();
        {supply_high, magnets_more} <= 2'h0;
        wr(10'h014, 32'h2);
        magnets_fewer <= 1'h1;
        quiet();
        magnets_more <= 1'h1;
        alarm(16'h9100);
        slow <= 1'h1;
        wr(10'h018, 32'h1);
        {supply_high, supply_low} <= 2'h3;
        alarm(16'h9111);
        alarm(16'h9110);
        supply_low <= 1'h0;
        wr(10'h018, 32'h3);
        supply_low <= 1'h1;
        alarm(16'h9110);
        slow <= 1'h0;
        wr(10'h010, 32'h1);
        chk(lin_on === 1'h0, "lin refused");
        alarm(16'h0010);
        lin_table_stored <= 1'h1;
        wr(10'h010, 32'h1);
        chk(lin_on === 1'h1, "lin on");
        wr(10'h034, 32'hf9);
        wr(10'h00c, 32'h1);
        chk(extrap_on === 1'h0, "extrap refused");
        alarm(16'h0010);
        wr(10'h034, 32'hfa);
        wr(10'h00c, 32'h1);
        chk(extrap_on === 1'h1, "extrap on");
        wr(10'h01c, 32'hffff_fff3);
        wr(10'h024, 32'hffff_ffff);
        wr(10'h030, 32'h8000_0000);
        settle();
        chk(loads == 0 && profile_override_param === 32'h0, "flags");
        rd(10'h02c, 32'h0001_0010);
        wr(10'h02c, 32'h0001_0000);
        rd(10'h02c, 32'h0000_0010);
        wr(10'h030, 32'h10);
        settle();
        chk(loads == 1 && preset_value === 32'h10, "preset");
        wr(10'h01c, 32'h4);
        wr(10'h030, 32'hffff_fff0);
        settle();
        chk(loads == 2 && preset_value === 32'hffff_fff0, "neg preset");
        wr(10'h020, 32'h1234);
        rd(10'h028, 32'h0);
        wr(10'h01c, 32'h8);
        rd(10'h028, 32'h1234);
        wr(10'h020, 32'h55);
        rd(10'h028, 32'h55);
        @(posedge sys_clk);
        status_idx  <= 5'h05;
        status_data <= 32'hdead_0005;
        status_wr   <= 1'h1;
        @(posedge sys_clk);
        status_wr <= 1'h0;
        repeat (31) @(posedge sys_clk);
        rd(10'h104, 32'h3);
        rd(10'h100, 32'h13);
        rd(10'h114, 32'hdead_0005);
        rd(10'h3fc, 32'h0);
        rst <= 1'h1;
        @(posedge sys_clk);
        #1;
        chk(velocity_window === 5'h08 && extrap_on === 1'h0, "mid reset");
        rst <= 1'h0;
        rd(10'h008, 32'h8);
        final_report();
    end
endmodule // tb_top
